// ==== src/dlct_pkg.sv ====
/*
  Package for the dual legacy counter/timer: register word addresses,
  field positions, reset values and the mode encoding.
  Assumes a 32-bit Avalon-MM slave with word addressing in bytes.
*/
package dlct_pkg;
  // ==========================================================================
  // Register word indexes (register offsets are word indexes, byte = 4 * index).
  // ==========================================================================
  localparam logic [7:0] CTRL_INDEX = 8'h88;
  localparam logic [7:0] MODE_INDEX = 8'h89;
  localparam logic [7:0] DIV_INDEX = 8'h8E;
  localparam logic [7:0] T0_LOW_INDEX = 8'h8A;
  localparam logic [7:0] T1_LOW_INDEX = 8'h8B;
  localparam logic [7:0] T0_HIGH_INDEX = 8'h8C;
  localparam logic [7:0] T1_HIGH_INDEX = 8'h8D;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [7:0] DIV_WRITE_MASK = 8'h38;
  // ==========================================================================
  // Field positions.
  // ==========================================================================
  localparam int CTRL_T1_FLAG = 7;
  localparam int CTRL_T1_RUN = 6;
  localparam int CTRL_T0_FLAG = 5;
  localparam int CTRL_T0_RUN = 4;
  localparam int MODE_T1_GATE = 7;
  localparam int MODE_T1_CNT = 6;
  localparam int MODE_T1_FIELD = 4;
  localparam int MODE_T0_GATE = 3;
  localparam int MODE_T0_CNT = 2;
  localparam int MODE_T0_FIELD = 0;
  localparam int DIV_T0_BIT = 3;
  localparam int DIV_T1_BIT = 4;
  // ==========================================================================
  // Timing: slow tick divide ratio.
  // ==========================================================================
  localparam int TICK_DIVIDE = 12;
  localparam logic [3:0] TICK_LAST = 4'(TICK_DIVIDE - 1);

  typedef enum logic [1:0] {
    DLCT_MODE_13 = 2'h0,
    DLCT_MODE_16 = 2'h1,
    DLCT_MODE_RELOAD = 2'h2,
    DLCT_MODE_SPLIT = 2'h3
  } dlct_mode_t;

  // Per-timer configuration carrier.
  typedef struct packed {
    logic run;
    logic gate;
    logic cnt_sel;
    logic fast;
    dlct_mode_t mode;
  } dlct_cfg_t;
endpackage : dlct_pkg

// ==== src/dlct_timer.sv ====
/*
  Dual legacy counter/timer: two 16-bit counters with 13-bit, 16-bit,
  8-bit auto-reload and split modes, reached over Avalon-MM.
  Assumes count and gate pins are synchronous to core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module dlct_timer (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic t0_count_pin,
  input wire logic t1_count_pin,
  input wire logic t0_gate_input_n,
  input wire logic t1_gate_input_n,
  input wire logic t0_int_ack,
  input wire logic t1_int_ack,
  output logic t1_baud_overflow,
  output logic t0_irq_flag,
  output logic t1_irq_flag
);
  // ==========================================================================
  // Registers and helpers.
  // ==========================================================================
  logic [7:0] timer_run_and_flag_control;
  logic [7:0] timer_mode_select;
  logic [7:0] timer_tick_divider_select;
  logic [7:0] t0_low_byte, t0_high_byte, t1_low_byte, t1_high_byte;
  logic [3:0] div_cnt;
  logic slow_tick;
  logic [1:0] pin_q;
  logic ack_phase;
  logic wr_go, rd_go;
  logic [7:0] wbyte;
  logic [7:0] idx;
  dlct_pkg::dlct_cfg_t cfg0, cfg1;
  logic tick0, tick1, th0_tick;
  logic en0, en1, en_th0;
  logic ovf0, ovf1, ovf_th0;
  logic t0_split;
  logic [7:0] next_t0_low, next_t0_high, next_t1_low, next_t1_high;

  // Address decode helper, used for the write paths; the read path decodes idx in a case.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_idx);
    hit = (a == reg_idx);
  endfunction : hit

  // Byte address to register index; the two low address bits are ignored.
  assign idx = avs_address[9:2];
  assign wbyte = avs_writedata[7:0];
  // One wait state: every access completes on the second edge.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_phase;
  assign wr_go = avs_write & ack_phase & avs_byteenable[0];
  assign rd_go = avs_read & ack_phase;

  // Wait-state toggler; clears on the completing edge, even while the request is held.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_phase <= 1'b0;
    end else begin
      ack_phase <= (avs_read | avs_write) & ~ack_phase;
    end
  end

  // ==========================================================================
  // Configuration unpacking.
  // ==========================================================================
  assign cfg0.run = timer_run_and_flag_control[dlct_pkg::CTRL_T0_RUN];
  assign cfg0.gate = timer_mode_select[dlct_pkg::MODE_T0_GATE];
  assign cfg0.cnt_sel = timer_mode_select[dlct_pkg::MODE_T0_CNT];
  assign cfg0.fast = timer_tick_divider_select[dlct_pkg::DIV_T0_BIT];
  assign cfg0.mode = dlct_pkg::dlct_mode_t'(timer_mode_select[dlct_pkg::MODE_T0_FIELD +: 2]);
  assign cfg1.run = timer_run_and_flag_control[dlct_pkg::CTRL_T1_RUN];
  assign cfg1.gate = timer_mode_select[dlct_pkg::MODE_T1_GATE];
  assign cfg1.cnt_sel = timer_mode_select[dlct_pkg::MODE_T1_CNT];
  assign cfg1.fast = timer_tick_divider_select[dlct_pkg::DIV_T1_BIT];
  assign cfg1.mode = dlct_pkg::dlct_mode_t'(timer_mode_select[dlct_pkg::MODE_T1_FIELD +: 2]);
  assign t0_split = (cfg0.mode == dlct_pkg::DLCT_MODE_SPLIT);

  // ==========================================================================
  // Tick generation: divide-by-12 enable and pin falling edges.
  // ==========================================================================
  // Free-running divider so the slow tick phase never depends on run bits.
  // The first slow tick after reset therefore falls on the twelfth edge.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt <= 4'h0;
    end else if (div_cnt == dlct_pkg::TICK_LAST) begin
      div_cnt <= 4'h0;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end
  assign slow_tick = (div_cnt == dlct_pkg::TICK_LAST);

  // Previous pin levels; inputs are already synchronous so one stage suffices.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_q <= 2'h0;
    end else begin
      pin_q <= {t1_count_pin, t0_count_pin};
    end
  end

  // Tick source per timer; timer 1 loses the pin source while timer 0 is split.
  // The split high byte of timer 0 follows timer 0's divider bit, never the pin.
  assign tick0 = cfg0.cnt_sel ? (pin_q[0] & ~t0_count_pin)
               : (cfg0.fast | slow_tick);
  assign tick1 = (cfg1.cnt_sel & ~t0_split) ? (pin_q[1] & ~t1_count_pin)
               : (cfg1.fast | slow_tick);
  assign th0_tick = cfg0.fast | slow_tick;

  // Enable: run and (no gate or gate input high).
  assign en0 = cfg0.run & (~cfg0.gate | t0_gate_input_n) & tick0;
  // Timer 1 still runs while timer 0 is split; only its own split field stops it.
  assign en1 = cfg1.run & (~cfg1.gate | t1_gate_input_n) & tick1
             & (cfg1.mode != dlct_pkg::DLCT_MODE_SPLIT);
  assign en_th0 = t0_split & cfg1.run & th0_tick;

  // ==========================================================================
  // Count next-state per timer.
  // ==========================================================================
  // Timer 0 next value and overflow.
  // In 13-bit mode low bits 7..5 simply hold; software must mask them on reads.
  always_comb begin
    next_t0_low = t0_low_byte;
    next_t0_high = t0_high_byte;
    ovf0 = 1'b0;
    ovf_th0 = 1'b0;
    case (cfg0.mode)
      dlct_pkg::DLCT_MODE_13: begin
        if (en0) begin
          {ovf0, next_t0_high, next_t0_low[4:0]} = {1'b0, t0_high_byte, t0_low_byte[4:0]} + 14'h0001;
        end
      end
      dlct_pkg::DLCT_MODE_16: begin
        if (en0) begin
          {ovf0, next_t0_high, next_t0_low} = {1'b0, t0_high_byte, t0_low_byte} + 17'h00001;
        end
      end
      dlct_pkg::DLCT_MODE_RELOAD: begin
        if (en0) begin
          {ovf0, next_t0_low} = {1'b0, t0_low_byte} + 9'h001;
          if (ovf0) begin
            next_t0_low = t0_high_byte;
          end
        end
      end
      default: begin
        if (en0) begin
          {ovf0, next_t0_low} = {1'b0, t0_low_byte} + 9'h001;
        end
        if (en_th0) begin
          {ovf_th0, next_t0_high} = {1'b0, t0_high_byte} + 9'h001;
        end
      end
    endcase
  end

  // Timer 1 next value and overflow; split mode holds the count.
  always_comb begin
    next_t1_low = t1_low_byte;
    next_t1_high = t1_high_byte;
    ovf1 = 1'b0;
    case (cfg1.mode)
      dlct_pkg::DLCT_MODE_13: begin
        if (en1) begin
          {ovf1, next_t1_high, next_t1_low[4:0]} = {1'b0, t1_high_byte, t1_low_byte[4:0]} + 14'h0001;
        end
      end
      dlct_pkg::DLCT_MODE_16: begin
        if (en1) begin
          {ovf1, next_t1_high, next_t1_low} = {1'b0, t1_high_byte, t1_low_byte} + 17'h00001;
        end
      end
      dlct_pkg::DLCT_MODE_RELOAD: begin
        if (en1) begin
          {ovf1, next_t1_low} = {1'b0, t1_low_byte} + 9'h001;
          if (ovf1) begin
            next_t1_low = t1_high_byte;
          end
        end
      end
      default: begin
        next_t1_low = t1_low_byte;
      end
    endcase
  end

  // ==========================================================================
  // Count registers: software writes win over counting in the same cycle.
  // ==========================================================================
  // A run-bit write never touches these bytes, so enabling keeps the count.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      t0_low_byte <= 8'h00;
      t0_high_byte <= 8'h00;
      t1_low_byte <= 8'h00;
      t1_high_byte <= 8'h00;
    end else begin
      t0_low_byte <= (wr_go && hit(idx, dlct_pkg::T0_LOW_INDEX)) ? wbyte : next_t0_low;
      t0_high_byte <= (wr_go && hit(idx, dlct_pkg::T0_HIGH_INDEX)) ? wbyte : next_t0_high;
      t1_low_byte <= (wr_go && hit(idx, dlct_pkg::T1_LOW_INDEX)) ? wbyte : next_t1_low;
      t1_high_byte <= (wr_go && hit(idx, dlct_pkg::T1_HIGH_INDEX)) ? wbyte : next_t1_high;
    end
  end

  // Mode and divider registers.
  // Divider bits other than 5..3 are masked on write, so they read back as zero; unused bit 5 keeps its written value.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_mode_select <= dlct_pkg::MODE_RESET;
      timer_tick_divider_select <= dlct_pkg::DIV_RESET;
    end else if (wr_go) begin
      if (hit(idx, dlct_pkg::MODE_INDEX)) begin
        timer_mode_select <= wbyte;
      end
      if (hit(idx, dlct_pkg::DIV_INDEX)) begin
        timer_tick_divider_select <= wbyte & dlct_pkg::DIV_WRITE_MASK;
      end
    end
  end

  // Control register: hardware set beats any clear in the same cycle.
  // Trade-off: a clear that meets an overflow is lost, so an event is never dropped.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_run_and_flag_control <= dlct_pkg::CTRL_RESET;
    end else begin
      if (wr_go && hit(idx, dlct_pkg::CTRL_INDEX)) begin
        timer_run_and_flag_control <= wbyte;
      end
      if (t0_int_ack) begin
        timer_run_and_flag_control[dlct_pkg::CTRL_T0_FLAG] <= 1'b0;
      end
      if (t1_int_ack) begin
        timer_run_and_flag_control[dlct_pkg::CTRL_T1_FLAG] <= 1'b0;
      end
      if (ovf0) begin
        timer_run_and_flag_control[dlct_pkg::CTRL_T0_FLAG] <= 1'b1;
      end
      if (ovf_th0 || (ovf1 && !t0_split)) begin
        timer_run_and_flag_control[dlct_pkg::CTRL_T1_FLAG] <= 1'b1;
      end
    end
  end

  // Timer 1 overflow pulse for baud generation, registered.
  // It keeps running while timer 0 is split, even though the flag is not set.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      t1_baud_overflow <= 1'b0;
    end else begin
      t1_baud_overflow <= ovf1;
    end
  end

  // Flags leave the block as levels for the interrupt logic.
  assign t0_irq_flag = timer_run_and_flag_control[dlct_pkg::CTRL_T0_FLAG];
  assign t1_irq_flag = timer_run_and_flag_control[dlct_pkg::CTRL_T1_FLAG];

  // Read data: registered on the first edge of a read; unmapped reads give zero.
  // Loading at the first edge keeps the data standing through the completing edge.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_phase) begin
      case (idx)
        dlct_pkg::CTRL_INDEX: avs_readdata <= {24'h000000, timer_run_and_flag_control};
        dlct_pkg::MODE_INDEX: avs_readdata <= {24'h000000, timer_mode_select};
        dlct_pkg::DIV_INDEX: avs_readdata <= {24'h000000, timer_tick_divider_select};
        dlct_pkg::T0_LOW_INDEX: avs_readdata <= {24'h000000, t0_low_byte};
        dlct_pkg::T1_LOW_INDEX: avs_readdata <= {24'h000000, t1_low_byte};
        dlct_pkg::T0_HIGH_INDEX: avs_readdata <= {24'h000000, t0_high_byte};
        dlct_pkg::T1_HIGH_INDEX: avs_readdata <= {24'h000000, t1_high_byte};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule : dlct_timer
`default_nettype wire

// ==== tb/dlct_timer_chk.sv ====
/*
  Checker for the counter/timer bus handshake and overflow flags.
  Assumes it is bound to dlct_timer and sees only that module's ports.
*/
`timescale 1ns/10ps
`default_nettype none
module dlct_timer_chk (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic t0_int_ack,
  input wire logic t1_int_ack,
  input wire logic t0_irq_flag,
  input wire logic t1_irq_flag
);
  // ==========================================================================
  // Helpers: a request, and a completed write to the control register.
  wire logic req = avs_read || avs_write;
  wire logic ctrl_wr = avs_write && !avs_waitrequest && avs_byteenable[0] && (avs_address[9:2] == 8'h88);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Every request waits exactly one cycle, and idle never waits.
  property p_first_wait; $rose(req) |-> avs_waitrequest; endproperty
  a_first_wait: assert property (p_first_wait) else $error("new request did not wait");
  property p_one_wait; req && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_one_wait: assert property (p_one_wait) else $error("request waited twice");
  property p_idle; !req |-> !avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("waitrequest high while idle");
  // Read data occupy the low lane; unmapped places read as zero.
  property p_upper; avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read lanes not zero");
  property p_unmapped;
    avs_read && !avs_waitrequest && (avs_address[9:2] < 8'h88 || avs_address[9:2] > 8'h8E) |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // A set flag only falls through software or an acknowledge.
  property p_hold0; t0_irq_flag && !t0_int_ack && !ctrl_wr |=> t0_irq_flag; endproperty
  a_hold0: assert property (p_hold0) else $error("timer 0 flag dropped by itself");
  property p_hold1; t1_irq_flag && !t1_int_ack && !ctrl_wr |=> t1_irq_flag; endproperty
  a_hold1: assert property (p_hold1) else $error("timer 1 flag dropped by itself");
  property p_set0; ctrl_wr && avs_writedata[5] && !t0_int_ack |=> t0_irq_flag; endproperty
  a_set0: assert property (p_set0) else $error("timer 0 flag write lost");
  property p_set1; ctrl_wr && avs_writedata[7] && !t1_int_ack |=> t1_irq_flag; endproperty
  a_set1: assert property (p_set1) else $error("timer 1 flag write lost");
  // Main scenarios reached.
  c_ack: cover property (t0_irq_flag && t0_int_ack);
  c_flag1: cover property ($rose(t1_irq_flag));
  c_unmapped: cover property (avs_read && !avs_waitrequest && avs_address[9:2] < 8'h88);
endmodule : dlct_timer_chk
bind dlct_timer dlct_timer_chk u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .t0_int_ack(t0_int_ack),
  .t1_int_ack(t1_int_ack), .t0_irq_flag(t0_irq_flag), .t1_irq_flag(t1_irq_flag));
`default_nettype wire

// ==== tb/dlct_pins.sv ====
/*
  Model of the external count and gate pins.
  Assumes the bench calls its tasks from a process synchronous to core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module dlct_pins (
  input wire logic core_clk,
  output logic t0_count_pin,
  output logic t1_count_pin,
  output logic t0_gate_input_n,
  output logic t1_gate_input_n
);
  // ==========================================================================
  // Pins idle high, so that idling never looks like a falling edge.
  initial begin
    t0_count_pin = 1'b1;
    t1_count_pin = 1'b1;
    t0_gate_input_n = 1'b1;
    t1_gate_input_n = 1'b1;
  end
  // Each level stands two clocks, so events never exceed a quarter of the clock.
  task pulse(input int ch, input int n);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge core_clk);
      if (ch == 0) t0_count_pin <= i[0];
      else t1_count_pin <= i[0];
      @(posedge core_clk);
    end
  endtask : pulse
  // Gate level for timer 0.
  task gate(input logic v);
    @(posedge core_clk);
    t0_gate_input_n <= v;
  endtask : gate
endmodule : dlct_pins
`default_nettype wire

// ==== tb/dlct_timer_tb.sv ====
/*
  Self-checking bench for dlct_timer: bus tasks and mode scenarios.
  Assumes the checker is bound in and dlct_pins drives the pins.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module dlct_timer_tb;
  logic core_clk, sys_rst, avs_read, avs_write, t0_int_ack, t1_int_ack, t0p, t1p, t0g, t1g, baud, f0, f1;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic avs_waitrequest;
  logic [7:0] r;
  int mismatches, n_checks, nb;
  // ==========================================================================
  // Design and pin model.
  dlct_timer DUT (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .t0_count_pin(t0p), .t1_count_pin(t1p),
    .t0_gate_input_n(t0g), .t1_gate_input_n(t1g), .t0_int_ack(t0_int_ack), .t1_int_ack(t1_int_ack),
    .t1_baud_overflow(baud), .t0_irq_flag(f0), .t1_irq_flag(f1));
  dlct_pins PIN (.core_clk(core_clk), .t0_count_pin(t0p), .t1_count_pin(t1p), .t0_gate_input_n(t0g),
    .t1_gate_input_n(t1g));
  // 50 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // One bus transfer; the request stands until waitrequest is sampled low at a rising edge.
  task bus(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge core_clk);
    avs_address <= {i, 2'b00};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge core_clk);
    end
    r = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task wr(input logic [7:0] i, input logic [7:0] d);
    bus(1'b1, i, d);
  endtask : wr
  task rd(input logic [7:0] i);
    bus(1'b0, i, 8'h00);
  endtask : rd
  // Verdict; the only way the run ends.
  task conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  // Watchdog: the tests need well under two thousand cycles.
  initial begin
    #100000;
    mismatches++;
    conclude();
  end
  // Main sequence.
  initial begin
    {sys_rst, avs_read, avs_write, t0_int_ack, t1_int_ack} = 5'h10;
    {avs_address, avs_writedata, avs_byteenable} = {10'h0, 32'h0, 4'hF};
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(8'h88); `CHK(r, 8'h00)
    rd(8'h89); `CHK(r, 8'h00)
    rd(8'h8E); `CHK(r, 8'h00)
    rd(8'h80); `CHK(r, 8'h00)
    wr(8'h8E, 8'hFF); rd(8'h8E); `CHK(r, 8'h38)
    wr(8'h88, 8'hA0); rd(8'h88); `CHK(r, 8'hA0)
    wr(8'h88, 8'h00);
    $display("test registers done");
    // Gated counter: pulses with the gate low must not count.
    wr(8'h89, 8'h0D); wr(8'h8A, 8'h40); PIN.gate(1'b0); wr(8'h88, 8'h10);
    PIN.pulse(0, 2); rd(8'h8A); `CHK(r, 8'h40)
    PIN.gate(1'b1); PIN.pulse(0, 3); rd(8'h8A); `CHK(r, 8'h43)
    $display("test gate done");
    // Reload counter: FE, FF, then reload FD and count once more.
    wr(8'h88, 8'h00); wr(8'h89, 8'h06); wr(8'h8C, 8'hFD); wr(8'h8A, 8'hFE); wr(8'h88, 8'h10);
    PIN.pulse(0, 3); rd(8'h8A); `CHK(r, 8'hFE)
    rd(8'h8C); `CHK(r, 8'hFD)
    `CHK(f0, 1'b1)
    wr(8'h88, 8'h20);
    @(posedge core_clk) t0_int_ack <= 1'b1;
    @(posedge core_clk) t0_int_ack <= 1'b0;
    @(posedge core_clk) `CHK(f0, 1'b0)
    $display("test reload done");
    // 13-bit then 16-bit rollover on one pin edge.
    for (int m = 0; m < 2; m++) begin
      wr(8'h89, 8'h04 + 8'(m)); wr(8'h8A, m ? 8'hFF : 8'h1F); wr(8'h8C, 8'hFF); wr(8'h88, 8'h10);
      PIN.pulse(0, 1); `CHK(f0, 1'b1)
      wr(8'h88, 8'h00); rd(8'h8C); `CHK(r, 8'h00)
      rd(8'h8A); `CHK(r & 8'h1F, 8'h00)
    end
    $display("test rollover done");
    // Slow tick: 123 counting edges give ten or eleven ticks of twelve.
    wr(8'h8E, 8'h00); wr(8'h89, 8'h01); wr(8'h8A, 8'h00); wr(8'h8C, 8'h00); wr(8'h88, 8'h10);
    repeat (120) @(posedge core_clk);
    wr(8'h88, 8'h00); rd(8'h8A); `CHK(r >= 8'h0A && r <= 8'h0B, 1'b1)
    $display("test tick done");
    // Split: high byte of timer 0 runs on timer 1 run bit; timer 1 holds.
    wr(8'h8B, 8'h55); wr(8'h8E, 8'h08); wr(8'h89, 8'h33); wr(8'h8C, 8'hFF); wr(8'h88, 8'h40);
    repeat (20) @(posedge core_clk);
    `CHK(f1, 1'b1)
    `CHK(f0, 1'b0)
    rd(8'h8B); `CHK(r, 8'h55)
    @(posedge core_clk) t1_int_ack <= 1'b1;
    @(posedge core_clk) t1_int_ack <= 1'b0;
    @(posedge core_clk) `CHK(f1, 1'b0)
    $display("test split done");
    // Timer 1 beside a split timer 0: pin source and flag are lost, baud pulses remain.
    wr(8'h88, 8'h00); wr(8'h8E, 8'h10); wr(8'h8C, 8'h00); wr(8'h8D, 8'hFE);
    wr(8'h8B, 8'hFE); wr(8'h89, 8'h63); wr(8'h88, 8'h40);
    nb = 0;
    repeat (2) @(posedge core_clk);
    repeat (10) begin
      @(posedge core_clk);
      if (baud === 1'b1) nb++;
    end
    `CHK(nb, 5)
    `CHK(f1, 1'b0)
    $display("test baud done");
    conclude();
  end
endmodule : dlct_timer_tb
`default_nettype wire
